// ---- sim/local_peer_window_decoder_tb_top.sv ----
// Self-checking bench for the local peer window decoder
`timescale 1ns/1ps
module local_peer_window_decoder_tb_top
  import lpw_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clk_en = 1'b1;
  lpw_cfg_t    cfg = '0;
  lpw_req_t    req = '0;
  logic [31:0] rdata;
  logic        ack;
  logic        vld;
  logic        loc;
  logic        lnk;
  int          mismatches = 0;
  int          num_checks = 0;
  int          exp_link = 0;
  int          link_seen;
  int          cycles = 0;

  // Clock enable is driven so the freeze scenario can drop it
  lpw_decoder dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .CLK_EN_I(clk_en),
    .CFG_I(cfg), .REQ_I(req), .CFG_RDATA_O(rdata), .CFG_ACK_O(ack),
    .REQ_VALID_O(vld), .REQ_LOCAL_O(loc), .REQ_TO_LINK_O(lnk));
  lpw_link_model link (.clk_i(clk), .rst_n_i(rst_n), .to_link_i(lnk),
    .taken_o(link_seen));

  always #2.5 clk = ~clk;

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Idle cycle after each access so no signal is driven twice per step
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [3:0] be, input logic [31:0] d,
                     input logic [31:0] e);
    cfg <= '{wr: w, rd: !w, addr: a, be: be, wdata: d};
    @(negedge clk);
    cfg <= '0;
    check({31'h0, ack}, 32'h1);
    check(rdata, e);
    @(negedge clk);
  endtask

  // Answer sampled half a cycle after the taking edge
  task automatic send(input lpw_kind_t k, input logic [31:0] a,
                      input logic l);
    logic [31:0] e;
    e = (k == LPW_KIND_NONE) ? 32'h0 : {29'h0, 1'b1, l, !l};
    req <= '{valid: 1'b1, kind: k, addr: a};
    @(negedge clk);
    req <= '0;
    check({29'h0, vld, loc, lnk}, e);
    if (k != LPW_KIND_NONE && !l)
      exp_link++;
    @(negedge clk);
  endtask

  // ==========================================================
  // Scenarios; each window is set before traffic uses it
  task automatic t_reset();
    acc(1'b0, 12'h108, 4'hF, 32'h0, 32'h0);
    acc(1'b0, 12'h10C, 4'hF, 32'h0, 32'h0);
    $display("done reset values");
  endtask

  task automatic t_io();
    acc(1'b1, 12'h108, 4'h3, 32'h0000_5F2F, 32'h0);
    acc(1'b0, 12'h108, 4'hF, 32'h0, 32'h0000_5020);
    send(LPW_KIND_IO, 32'h0000_1FFF, 1'b0);
    send(LPW_KIND_IO, 32'h0000_2000, 1'b1);
    send(LPW_KIND_IO, 32'h0000_5FFF, 1'b1);
    send(LPW_KIND_IO, 32'h0000_6000, 1'b0);
    $display("done io window");
  endtask

  task automatic t_io_off();
    acc(1'b1, 12'h108, 4'h3, 32'h0000_5060, 32'h0);
    send(LPW_KIND_IO, 32'h0000_5000, 1'b0);
    send(LPW_KIND_IO, 32'h0000_6000, 1'b0);
    $display("done io disabled");
  endtask

  task automatic t_mmio();
    acc(1'b1, 12'h10C, 4'hF, 32'h8011_1022, 32'h0);
    acc(1'b0, 12'h10C, 4'hF, 32'h0, 32'h8000_1000);
    send(LPW_KIND_MEM, 32'h0FFF_FFFF, 1'b0);
    send(LPW_KIND_MEM, 32'h1000_0000, 1'b1);
    send(LPW_KIND_MEM, 32'h80FF_FFFF, 1'b1);
    send(LPW_KIND_MEM, 32'h8100_0000, 1'b0);
    send(LPW_KIND_NONE, 32'h1000_0000, 1'b0);
    $display("done mmio window");
  endtask

  task automatic t_mmio_off();
    acc(1'b1, 12'h10C, 4'hF, 32'h8000_8100, 32'h0);
    send(LPW_KIND_MEM, 32'h8000_0000, 1'b0);
    acc(1'b0, 12'h200, 4'hF, 32'h0, 32'h0);
    $display("done mmio disabled");
  endtask

  // Low enable must hold every output; the read and request are lost
  task automatic t_freeze();
    clk_en <= 1'b0;
    cfg    <= '{wr: 1'b0, rd: 1'b1, addr: 12'h108, be: 4'hF, wdata: 32'h0};
    req    <= '{valid: 1'b1, kind: LPW_KIND_IO, addr: 32'h0000_9000};
    @(negedge clk);
    clk_en <= 1'b1;
    cfg    <= '0;
    req    <= '0;
    check({28'h0, ack, vld, loc, lnk}, 32'h0);
    check(rdata, 32'h0);
    @(negedge clk);
    $display("done clock enable freeze");
  endtask

  // reset returns the windows to their reset values, so later scenarios start from zero
  task automatic t_reboot();
    check(32'(link_seen), 32'(exp_link));
    exp_link = 0;
    rst_n <= 1'b0;
    repeat (2) @(negedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    acc(1'b0, 12'h108, 4'hF, 32'h0, 32'h0);
    $display("done reboot");
  endtask

  // ==========================================================
  // Closing report and hang guard
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Tests need well under a hundred cycles; far beyond that means a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      end_sim();
    end
  end

  // Main sequence
  initial begin
    repeat (8) @(negedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    t_reset();
    t_io();
    t_freeze();
    t_reboot();
    t_io_off();
    t_mmio();
    t_reboot();
    t_mmio_off();
    check(32'(link_seen), 32'(exp_link));
    end_sim();
  end
endmodule

// ---- sim/lpw_link_model.sv ----
// Link-side model: absorbs requests routed across the system link
`timescale 1ns/1ps
module lpw_link_model (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic to_link_i,
  output int        taken_o
);
  // always ready, so every routed request lands here at once
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      taken_o <= 0;
    else if (to_link_i)
      taken_o <= taken_o + 1;
  end
endmodule

// ---- verilog/lpw_decoder.sv ----
// Local peer window decoder: config registers and request classifier
// Functional notes
// - I/O window limit held in bits 15:12, compared with address 15:12.
// - I/O address 15:12 within base..limit inclusive is local peer.
// - I/O base above limit disables the I/O window.
// - Low MMIO base held in bits 15:8, matching address 31:24.
// - Low MMIO limit held in bits 31:24, matching address 31:24.
// - Memory address 31:24 within base..limit inclusive is local peer.
// - Low MMIO base above limit disables the memory window.
// - I/O window base in bits 7:4 of byte register at 108h.
`timescale 1ns/1ps
module lpw_decoder
  import lpw_pkg::*;
(
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        CLK_EN_I,
  input  wire lpw_cfg_t    CFG_I,
  input  wire lpw_req_t    REQ_I,
  output logic [31:0]      CFG_RDATA_O,
  output logic             CFG_ACK_O,
  output logic             REQ_VALID_O,
  output logic             REQ_LOCAL_O,
  output logic             REQ_TO_LINK_O
);

  // ==========================================================
  // Window registers
  logic [3:0] io_base;
  logic [3:0] io_limit;
  logic [7:0] mmio_base;
  logic [7:0] mmio_limit;
  logic [3:0] next_io_base;
  logic [3:0] next_io_limit;
  logic [7:0] next_mmio_base;
  logic [7:0] next_mmio_limit;
  logic [11:0] dw_addr;
  logic [11:0] cfg_dw;

  // Dword that holds a register; byte lanes pick the field
  assign cfg_dw  = {CFG_I.addr[11:2], 2'b00};
  assign dw_addr = {LPW_OFS_IO_BASE[11:2], 2'b00};

  // Register writes through byte enables
  always_comb begin
    next_io_base    = io_base;
    next_io_limit   = io_limit;
    next_mmio_base  = mmio_base;
    next_mmio_limit = mmio_limit;
    if (CFG_I.wr && cfg_dw == dw_addr) begin
      if (CFG_I.be[0])
        next_io_base = CFG_I.wdata[7:4];
      if (CFG_I.be[1])
        next_io_limit = CFG_I.wdata[15:12];
    end
    if (CFG_I.wr && cfg_dw == LPW_OFS_MMIO_BASE) begin
      if (CFG_I.be[1])
        next_mmio_base = CFG_I.wdata[15:8];
      if (CFG_I.be[3])
        next_mmio_limit = CFG_I.wdata[31:24];
    end
  end

  // Register the window fields
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      io_base    <= LPW_IO_RST;
      io_limit   <= LPW_IO_RST;
      mmio_base  <= LPW_MMIO_RST;
      mmio_limit <= LPW_MMIO_RST;
    end else if (CLK_EN_I) begin
      io_base    <= next_io_base;
      io_limit   <= next_io_limit;
      mmio_base  <= next_mmio_base;
      mmio_limit <= next_mmio_limit;
    end
  end

  // ==========================================================
  // Config read path
  logic [31:0] next_rdata;
  logic        next_ack;

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_ack   = CFG_I.rd || CFG_I.wr;
    if (CFG_I.rd && cfg_dw == dw_addr)
      next_rdata = {16'h0000, io_limit, 4'h0, io_base, 4'h0};
    else if (CFG_I.rd && cfg_dw == LPW_OFS_MMIO_BASE)
      next_rdata = {mmio_limit, 8'h00, mmio_base, 8'h00};
  end

  // Unmapped reads return zero; ack one cycle after request
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      CFG_RDATA_O <= 32'h0000_0000;
      CFG_ACK_O   <= 1'b0;
    end else if (CLK_EN_I) begin
      CFG_RDATA_O <= next_rdata;
      CFG_ACK_O   <= next_ack;
    end
  end

  // ==========================================================
  // Request classification
  logic io_hit;
  logic mem_hit;
  logic next_valid;
  logic next_local;
  logic next_link;

  lpw_range_chk #(.W(LPW_IO_FLD_W)) u_io_chk (
    .base_i  (io_base),
    .limit_i (io_limit),
    .value_i (REQ_I.addr[15:12]),
    .hit_o   (io_hit)
  );

  lpw_range_chk #(.W(LPW_MMIO_FLD_W)) u_mem_chk (
    .base_i  (mmio_base),
    .limit_i (mmio_limit),
    .value_i (REQ_I.addr[31:24]),
    .hit_o   (mem_hit)
  );

  always_comb begin
    next_valid = REQ_I.valid && (REQ_I.kind == LPW_KIND_IO ||
                                 REQ_I.kind == LPW_KIND_MEM);
    next_local = 1'b0;
    if (REQ_I.valid && REQ_I.kind == LPW_KIND_IO)
      next_local = io_hit;
    else if (REQ_I.valid && REQ_I.kind == LPW_KIND_MEM)
      next_local = mem_hit;
    next_link = next_valid && !next_local;
  end

  // Decision registered; one cycle latency
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      REQ_VALID_O   <= 1'b0;
      REQ_LOCAL_O   <= 1'b0;
      REQ_TO_LINK_O <= 1'b0;
    end else if (CLK_EN_I) begin
      REQ_VALID_O   <= next_valid;
      REQ_LOCAL_O   <= next_local;
      REQ_TO_LINK_O <= next_link;
    end
  end

  // ==========================================================
  // Checks
  // disabled I/O never local
  chk_io_disabled: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    CLK_EN_I && REQ_I.valid && REQ_I.kind == LPW_KIND_IO &&
    io_base > io_limit |=> !REQ_LOCAL_O)
    else $error("disabled io window matched");
  chk_mem_disabled: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    CLK_EN_I && REQ_I.valid && REQ_I.kind == LPW_KIND_MEM &&
    mmio_base > mmio_limit |=> !REQ_LOCAL_O)
    else $error("disabled mmio window matched");
  chk_io_inside: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    CLK_EN_I && REQ_I.valid && REQ_I.kind == LPW_KIND_IO &&
    REQ_I.addr[15:12] >= io_base && REQ_I.addr[15:12] <= io_limit
    |=> REQ_LOCAL_O && !REQ_TO_LINK_O)
    else $error("io in window not local");
  chk_mem_inside: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    CLK_EN_I && REQ_I.valid && REQ_I.kind == LPW_KIND_MEM &&
    REQ_I.addr[31:24] >= mmio_base && REQ_I.addr[31:24] <= mmio_limit
    |=> REQ_LOCAL_O)
    else $error("mem in window not local");
  chk_miss_link: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    REQ_VALID_O |-> (REQ_LOCAL_O ^ REQ_TO_LINK_O))
    else $error("request not routed exactly once");
  chk_io_limit_wr: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    CLK_EN_I && CFG_I.wr && cfg_dw == dw_addr && CFG_I.be[1]
    |=> io_limit == $past(CFG_I.wdata[15:12]))
    else $error("io limit write lost");
  chk_io_base_wr: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    CLK_EN_I && CFG_I.wr && cfg_dw == dw_addr && CFG_I.be[0]
    |=> io_base == $past(CFG_I.wdata[7:4]))
    else $error("io base write lost");
  chk_mmio_base_wr: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    CLK_EN_I && CFG_I.wr && cfg_dw == LPW_OFS_MMIO_BASE && CFG_I.be[1]
    |=> mmio_base == $past(CFG_I.wdata[15:8]))
    else $error("mmio base write lost");
  chk_mmio_lim_wr: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    CLK_EN_I && CFG_I.wr && cfg_dw == LPW_OFS_MMIO_BASE && CFG_I.be[3]
    |=> mmio_limit == $past(CFG_I.wdata[31:24]))
    else $error("mmio limit write lost");
  chk_rsvd_zero: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    CFG_ACK_O |-> CFG_RDATA_O[3:0] == 4'h0 && CFG_RDATA_O[11:8] == 4'h0
    && CFG_RDATA_O[23:16] == 8'h00)
    else $error("reserved bits not zero");

endmodule

// ---- verilog/lpw_pkg.sv ----
// Package: offsets, field layout, reset values and carriers for the decoder
package lpw_pkg;

  // ==========================================================
  // Configuration offsets (byte addresses in config space)
  localparam logic [11:0] LPW_OFS_IO_BASE    = 12'h0108;
  localparam logic [11:0] LPW_OFS_IO_LIMIT   = 12'h0109;
  localparam logic [11:0] LPW_OFS_MMIO_BASE  = 12'h010C;
  localparam logic [11:0] LPW_OFS_MMIO_LIMIT = 12'h010E;

  // ==========================================================
  // Field positions and widths
  localparam int LPW_IO_FLD_LSB   = 4;
  localparam int LPW_IO_FLD_W     = 4;
  localparam int LPW_MMIO_FLD_LSB = 8;
  localparam int LPW_MMIO_FLD_W   = 8;
  localparam int LPW_IO_ADDR_LSB  = 12;
  localparam int LPW_MEM_ADDR_LSB = 24;

  // ==========================================================
  // Reset values
  localparam logic [3:0] LPW_IO_RST   = 4'h0;
  localparam logic [7:0] LPW_MMIO_RST = 8'h00;

  // ==========================================================
  // Carriers
  typedef enum logic [1:0] {
    LPW_KIND_NONE = 2'b00,
    LPW_KIND_IO   = 2'b01,
    LPW_KIND_MEM  = 2'b10
  } lpw_kind_t;

  typedef struct packed {
    logic        valid;
    lpw_kind_t   kind;
    logic [31:0] addr;
  } lpw_req_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } lpw_cfg_t;

endpackage

// ---- verilog/lpw_range_chk.sv ----
// Inclusive range compare with base above limit meaning disabled
`timescale 1ns/1ps
module lpw_range_chk
  import lpw_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic [W-1:0] base_i,
  input  wire logic [W-1:0] limit_i,
  input  wire logic [W-1:0] value_i,
  output logic              hit_o
);

  // ==========================================================
  // Width guard; a field wider than an address word has no meaning
  if (W < 1 || W > 32) begin : g_bad_width
    $error("lpw_range_chk: W must lie in 1..32");
  end

  // ==========================================================
  // Compare
  // disabled window
  always_comb begin
    hit_o = (base_i <= limit_i) && (value_i >= base_i) &&
            (value_i <= limit_i);
  end

endmodule
